// ### core/two_wire_ctrl.v
// two-wire bus controller top: line sampling, master engine, slave hookup
`timescale 1ns/1ps
`include "two_wire_defines.vh"
module two_wire_ctrl (
   // clock and reset
   input wire clock,
   input wire rst,
   // bus lines, open drain
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe_n,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_n,
   // configuration
   input wire fast,
   // master command
   input wire m_go,
   input wire [6:0] m_addr,
   input wire m_rw,
   input wire [7:0] m_tx_data,
   // master status and events
   output reg m_busy,
   output reg m_done,
   output reg m_error,
   output reg m_nack,
   output reg m_arb_lost,
   output reg [7:0] m_rx_data,
   // slave side
   input wire s_enable,
   input wire [6:0] s_addr,
   input wire [7:0] s_tx_data,
   output wire [7:0] s_rx_data,
   output wire s_rx_valid,
   output wire s_data_req,
   output wire s_data_sent,
   // bus state and mode
   output reg bus_busy,
   output reg [3:0] mode
);
   localparam integer std_half_full = `STD_HALF_CYC;
   localparam integer fast_half_full = `FAST_HALF_CYC;
   localparam [7:0] std_half = std_half_full[7:0];
   localparam [7:0] fast_half = fast_half_full[7:0];

   reg scl_m, scl_q, scl_d;
   reg sda_m, sda_q, sda_d;
   reg [5:0] state;
   reg [7:0] cnt;
   reg [3:0] bitn;
   reg [7:0] sh;
   reg phase;
   reg pend;
   reg [6:0] addr;
   reg rw;
   reg [7:0] txd;
   reg scl_pull;
   reg sda_pull;
   wire [7:0] half;
   wire tx_mode;
   wire scl_rise, scl_fall, start_det, stop_det;
   wire s_pull, s_tx_act, s_rx_act;

   assign half = fast ? fast_half : std_half;
   // address phase and write data are sent, read data is received
   assign tx_mode = !(phase && rw == `RW_READ);
   assign scl_rise = scl_q && !scl_d;
   assign scl_fall = !scl_q && scl_d;
   assign start_det = scl_q && scl_d && sda_d && !sda_q;
   assign stop_det = scl_q && scl_d && !sda_d && sda_q;

   // pins arrive asynchronously, two flops before use
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_q <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_q <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl_i;
         scl_q <= scl_m;
         scl_d <= scl_q;
         sda_m <= sda_i;
         sda_q <= sda_m;
         sda_d <= sda_q;
      end
   end

   // pads and bus state
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         bus_busy <= 1'b0;
         mode <= 4'h0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_n <= ~scl_pull;
         sda_oe_n <= ~(sda_pull | s_pull);
         if (start_det) begin
            bus_busy <= 1'b1;
         end else if (stop_det) begin
            bus_busy <= 1'b0;
         end
         mode <= {s_rx_act, s_tx_act, (state != `M_IDLE) && rw == `RW_READ,
                  (state != `M_IDLE) && rw != `RW_READ};
      end
   end

   // master engine
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= `M_IDLE;
         cnt <= 8'h00;
         bitn <= 4'h0;
         sh <= 8'h00;
         phase <= 1'b0;
         pend <= 1'b0;
         addr <= 7'h00;
         rw <= 1'b0;
         txd <= 8'h00;
         scl_pull <= 1'b0;
         sda_pull <= 1'b0;
         m_busy <= 1'b0;
         m_done <= 1'b0;
         m_error <= 1'b0;
         m_nack <= 1'b0;
         m_arb_lost <= 1'b0;
         m_rx_data <= 8'h00;
      end else begin
         m_done <= 1'b0;
         m_error <= 1'b0;
         m_busy <= pend || (state != `M_IDLE) || (m_go && !m_busy);
         case (state)
            `M_IDLE: begin
               scl_pull <= 1'b0;
               sda_pull <= 1'b0;
               cnt <= 8'h00;
               // commands while busy are dropped, the user waits for m_busy low
               if (m_go && !m_busy) begin
                  pend <= 1'b1;
                  addr <= m_addr;
                  rw <= m_rw;
                  txd <= m_tx_data;
                  m_nack <= 1'b0;
                  m_arb_lost <= 1'b0;
               end
               if (pend && !bus_busy && scl_q && sda_q) begin
                  pend <= 1'b0;
                  sda_pull <= 1'b1;
                  state <= `M_START;
               end
            end
            `M_START: begin
               if (cnt == half) begin
                  scl_pull <= 1'b1;
                  cnt <= 8'h00;
                  bitn <= 4'h0;
                  phase <= 1'b0;
                  sh <= {addr, rw};
                  state <= `M_LOW;
               end else begin
                  cnt <= cnt + 8'h01;
               end
            end
            `M_LOW: begin
               // data changes only while the clock is low
               if (cnt == 8'h00) begin
                  sda_pull <= (bitn != `ACK_SLOT) && tx_mode && !sh[`BYTE_MSB];
               end
               if (cnt == half) begin
                  scl_pull <= 1'b0;
                  cnt <= 8'h00;
                  state <= `M_HIGH;
               end else begin
                  cnt <= cnt + 8'h01;
               end
            end
            `M_HIGH: begin
               if (!scl_q) begin
                  cnt <= 8'h00;
               end else if (cnt != half) begin
                  cnt <= cnt + 8'h01;
               end else begin
                  cnt <= 8'h00;
                  scl_pull <= 1'b1;
                  if (bitn != `ACK_SLOT) begin
                     if (tx_mode && sh[`BYTE_MSB] && !sda_q) begin
                        scl_pull <= 1'b0;
                        sda_pull <= 1'b0;
                        m_arb_lost <= 1'b1;
                        m_error <= 1'b1;
                        state <= `M_IDLE;
                     end else begin
                        sh <= {sh[6:0], sda_q};
                        bitn <= bitn + 4'h1;
                        state <= `M_LOW;
                     end
                  end else if (tx_mode && sda_q) begin
                     m_nack <= 1'b1;
                     state <= `M_STOP;
                  end else if (!phase) begin
                     phase <= 1'b1;
                     sh <= (rw == `RW_READ) ? 8'h00 : txd;
                     bitn <= 4'h0;
                     state <= `M_LOW;
                  end else begin
                     // a single read byte ends with a released ack slot
                     if (rw == `RW_READ) begin
                        m_rx_data <= sh;
                     end
                     state <= `M_STOP;
                  end
               end
            end
            `M_STOP: begin
               if (cnt == 8'h00) begin
                  sda_pull <= 1'b1;
               end
               if (cnt == half) begin
                  scl_pull <= 1'b0;
                  cnt <= 8'h00;
                  state <= `M_STOPH;
               end else begin
                  cnt <= cnt + 8'h01;
               end
            end
            `M_STOPH: begin
               if (!scl_q) begin
                  cnt <= 8'h00;
               end else if (cnt != half) begin
                  cnt <= cnt + 8'h01;
               end else begin
                  sda_pull <= 1'b0;
                  cnt <= 8'h00;
                  m_done <= !m_nack;
                  m_error <= m_nack;
                  state <= `M_IDLE;
               end
            end
            default: begin
               scl_pull <= 1'b0;
               sda_pull <= 1'b0;
               state <= `M_IDLE;
            end
         endcase
      end
   end

   two_wire_slave slave (
      .clock(clock),
      .rst(rst),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .sda_q(sda_q),
      .start_det(start_det),
      .stop_det(stop_det),
      .enable(s_enable),
      .own_addr(s_addr),
      .tx_data(s_tx_data),
      .sda_pull(s_pull),
      .rx_data(s_rx_data),
      .rx_valid(s_rx_valid),
      .data_req(s_data_req),
      .data_sent(s_data_sent),
      .tx_active(s_tx_act),
      .rx_active(s_rx_act)
   );
endmodule

// ### core/two_wire_defines.vh
// timing, field and encoding constants for the two-wire controller
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH
// system clock period and bus bit periods
`define CLK_NS 100
`define STD_BIT_NS 10000
`define FAST_BIT_NS 2500
// half bit in clock cycles, rounded down; the counters run 0 to half, so each phase lasts half+1 cycles
`define STD_HALF_CYC ((`STD_BIT_NS / 2) / `CLK_NS)
`define FAST_HALF_CYC ((`FAST_BIT_NS / 2) / `CLK_NS)
// bit positions within a byte slot
`define BYTE_MSB 7
`define LAST_DATA_BIT 4'h7
`define ACK_SLOT 4'h8
`define RW_READ 1'h1
// master states, one-hot
`define M_IDLE 6'h01
`define M_START 6'h02
`define M_LOW 6'h04
`define M_HIGH 6'h08
`define M_STOP 6'h10
`define M_STOPH 6'h20
// slave states, one-hot
`define S_IDLE 7'h01
`define S_ADDR 7'h02
`define S_AACK 7'h04
`define S_RX 7'h08
`define S_DACK 7'h10
`define S_TX 7'h20
`define S_TACK 7'h40
`endif

// ### core/two_wire_slave.v
// slave engine of the two-wire controller, fed with synchronised line events
`timescale 1ns/1ps
`include "two_wire_defines.vh"
module two_wire_slave (
   // clock and reset
   input wire clock,
   input wire rst,
   // line events from the top
   input wire scl_rise,
   input wire scl_fall,
   input wire sda_q,
   input wire start_det,
   input wire stop_det,
   // user side
   input wire enable,
   input wire [6:0] own_addr,
   input wire [7:0] tx_data,
   output reg sda_pull,
   output reg [7:0] rx_data,
   output reg rx_valid,
   output reg data_req,
   output reg data_sent,
   output wire tx_active,
   output wire rx_active
);
   reg [6:0] state;
   reg [3:0] bitn;
   reg [7:0] sh;
   reg acked;

   assign tx_active = (state == `S_TX) || (state == `S_TACK);
   assign rx_active = (state == `S_RX) || (state == `S_DACK);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= `S_IDLE;
         bitn <= 4'h0;
         sh <= 8'h00;
         acked <= 1'b0;
         sda_pull <= 1'b0;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         data_req <= 1'b0;
         data_sent <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         data_req <= 1'b0;
         data_sent <= 1'b0;
         if (start_det && enable) begin
            state <= `S_ADDR;
            bitn <= 4'h0;
            sda_pull <= 1'b0;
         end else if (stop_det || !enable) begin
            state <= `S_IDLE;
            sda_pull <= 1'b0;
         end else begin
            case (state)
               `S_IDLE: begin
                  sda_pull <= 1'b0;
               end
               `S_ADDR: begin
                  if (scl_rise) begin
                     sh <= {sh[6:0], sda_q};
                     bitn <= bitn + 4'h1;
                  end
                  if (scl_fall && bitn == `ACK_SLOT) begin
                     if (sh[7:1] == own_addr) begin
                        sda_pull <= 1'b1;
                        state <= `S_AACK;
                        data_req <= sh[0] == `RW_READ;
                     end else begin
                        state <= `S_IDLE;
                     end
                  end
               end
               `S_AACK: begin
                  if (scl_fall) begin
                     bitn <= 4'h0;
                     if (sh[0] == `RW_READ) begin
                        sh <= tx_data;
                        sda_pull <= ~tx_data[`BYTE_MSB];
                        state <= `S_TX;
                     end else begin
                        sda_pull <= 1'b0;
                        state <= `S_RX;
                     end
                  end
               end
               `S_RX: begin
                  if (scl_rise) begin
                     sh <= {sh[6:0], sda_q};
                     bitn <= bitn + 4'h1;
                  end
                  if (scl_fall && bitn == `ACK_SLOT) begin
                     sda_pull <= 1'b1;
                     rx_data <= sh;
                     rx_valid <= 1'b1;
                     state <= `S_DACK;
                  end
               end
               `S_DACK: begin
                  if (scl_fall) begin
                     sda_pull <= 1'b0;
                     bitn <= 4'h0;
                     state <= `S_RX;
                  end
               end
               `S_TX: begin
                  if (scl_fall) begin
                     if (bitn[2:0] == `LAST_DATA_BIT) begin
                        sda_pull <= 1'b0;
                        state <= `S_TACK;
                     end else begin
                        bitn <= bitn + 4'h1;
                        sda_pull <= ~sh[`BYTE_MSB - 1];
                        sh <= {sh[6:0], 1'b0};
                     end
                  end
               end
               `S_TACK: begin
                  if (scl_rise) begin
                     data_sent <= 1'b1;
                     acked <= ~sda_q;
                     data_req <= ~sda_q;
                  end
                  if (scl_fall) begin
                     bitn <= 4'h0;
                     if (acked) begin
                        sh <= tx_data;
                        sda_pull <= ~tx_data[`BYTE_MSB];
                        state <= `S_TX;
                     end else begin
                        state <= `S_IDLE;
                     end
                  end
               end
               default: begin
                  state <= `S_IDLE;
                  sda_pull <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ### tb/bus_target_model.sv
// behavioural target device on the far side of the two-wire bus
`timescale 1ns/1ps
module bus_target_model #(
   parameter logic [6:0] ADDR = 7'h50
) (
   // bus lines
   input wire logic scl,
   input wire logic sda,
   output logic scl_rel,
   output logic sda_rel,
   // user side
   input wire logic stretch,
   input wire logic [7:0] rd_byte,
   output logic [7:0] wr_byte
);
   logic [7:0] sh;
   integer i;
   task get_byte;
      repeat (8) @(posedge scl) sh = {sh[6:0], sda};
   endtask
   task put_bit(input logic b);
      @(negedge scl);
      if (stretch) begin
         scl_rel = 1'b0;
         #230 sda_rel = b;
         #1770 scl_rel = 1'b1;
      end else
         #230 sda_rel = b;
   endtask
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
      wr_byte = 8'h00;
      sh = 8'h00;
      forever begin
         @(negedge sda iff scl === 1'b1);
         get_byte();
         if (sh[7:1] == ADDR) begin
            put_bit(1'b0);
            if (sh[0]) begin
               for (i = 7; i >= 0; i = i - 1)
                  put_bit(rd_byte[i]);
               put_bit(1'b1);
            end else begin
               put_bit(1'b1);
               get_byte();
               wr_byte = sh;
               put_bit(1'b0);
               put_bit(1'b1);
            end
         end
      end
   end
endmodule

// ### tb/testbench.sv
// self-checking bench for the two-wire controller
`timescale 1ns/1ps
module testbench;
   logic clock, rst, fast, m_go, m_rw, s_enable, stretch, jam_n, p_scl, p_sda;
   logic [6:0] m_addr, s_addr;
   logic [7:0] m_tx_data, s_tx_data, rd_byte, p_wr_byte, m_rx_data, s_rx_data;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_busy, m_done, m_error, m_nack, m_arb_lost;
   logic s_rx_valid, s_data_req, s_data_sent, bus_busy;
   logic [3:0] mode, mode_seen;
   logic rxv_seen, req_seen, sent_seen, done_seen, err_seen, bb_seen;
   wire scl_line = (scl_oe_n | scl_o) & p_scl;
   wire sda_line = (sda_oe_n | sda_o) & p_sda & jam_n;
   integer fails, check_count, k;
   two_wire_ctrl u_dut (.clock(clock), .rst(rst), .scl_i(scl_line), .scl_o(scl_o),
      .scl_oe_n(scl_oe_n), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .fast(fast), .m_go(m_go), .m_addr(m_addr), .m_rw(m_rw), .m_tx_data(m_tx_data),
      .m_busy(m_busy), .m_done(m_done), .m_error(m_error), .m_nack(m_nack),
      .m_arb_lost(m_arb_lost), .m_rx_data(m_rx_data), .s_enable(s_enable),
      .s_addr(s_addr), .s_tx_data(s_tx_data), .s_rx_data(s_rx_data),
      .s_rx_valid(s_rx_valid), .s_data_req(s_data_req), .s_data_sent(s_data_sent),
      .bus_busy(bus_busy), .mode(mode));
   bus_target_model #(.ADDR(7'h50)) u_target (.scl(scl_line), .sda(sda_line),
      .scl_rel(p_scl), .sda_rel(p_sda), .stretch(stretch), .rd_byte(rd_byte),
      .wr_byte(p_wr_byte));
   always #50 clock = ~clock;
   task check_val(input logic [7:0] got, input logic [7:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task check_bit(input logic got, input logic exp);
      check_val({7'h00, got}, {7'h00, exp});
   endtask
   task tally_and_finish;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one master transfer, gathering events until it ends
   task run_master(input logic [6:0] a, input logic rw, input logic [7:0] d, input logic f);
      integer n;
      @(negedge clock);
      {m_addr, m_rw, m_tx_data, fast, m_go} = {a, rw, d, f, 1'b1};
      {mode_seen, rxv_seen, req_seen, sent_seen, done_seen, err_seen, bb_seen} = 10'h000;
      @(negedge clock);
      m_go = 1'b0;
      for (n = 0; n < 6000 && !done_seen && !err_seen; n = n + 1) begin
         @(negedge clock);
         mode_seen = mode_seen | mode;
         rxv_seen = rxv_seen | s_rx_valid;
         req_seen = req_seen | s_data_req;
         sent_seen = sent_seen | s_data_sent;
         done_seen = done_seen | m_done;
         err_seen = err_seen | m_error;
         bb_seen = bb_seen | bus_busy;
      end
      if (n == 6000)
         fails = fails + 1;
      repeat (20) @(negedge clock);
   endtask
   task t_write;
      run_master(7'h50, 1'b0, 8'ha5, 1'b0);
      check_bit(done_seen, 1'b1);
      check_val(p_wr_byte, 8'ha5);
      check_val({4'h0, mode_seen}, 8'h01);
      check_bit(bb_seen, 1'b1);
      check_bit(bus_busy, 1'b0);
   endtask
   task t_read_fast;
      {stretch, rd_byte} = {1'b1, 8'h3c};
      run_master(7'h50, 1'b1, 8'h00, 1'b1);
      stretch = 1'b0;
      check_bit(done_seen, 1'b1);
      check_val(m_rx_data, 8'h3c);
      check_val({4'h0, mode_seen}, 8'h02);
   endtask
   task t_nack;
      run_master(7'h21, 1'b0, 8'h11, 1'b0);
      check_bit(err_seen, 1'b1);
      check_bit(m_nack, 1'b1);
      check_bit(done_seen, 1'b0);
   endtask
   task t_own_write;
      run_master(7'h2a, 1'b0, 8'hc3, 1'b1);
      check_bit(done_seen, 1'b1);
      check_bit(rxv_seen, 1'b1);
      check_val(s_rx_data, 8'hc3);
      check_bit(mode_seen[3], 1'b1);
   endtask
   task t_own_read;
      s_tx_data = 8'h96;
      run_master(7'h2a, 1'b1, 8'h00, 1'b0);
      check_val(m_rx_data, 8'h96);
      check_bit(req_seen, 1'b1);
      check_bit(sent_seen, 1'b1);
      check_bit(mode_seen[2], 1'b1);
   endtask
   task t_slave_off;
      s_enable = 1'b0;
      run_master(7'h2a, 1'b0, 8'h5a, 1'b0);
      s_enable = 1'b1;
      check_bit(err_seen, 1'b1);
      check_bit(rxv_seen, 1'b0);
   endtask
   // jam the data line low after the start so the sent 1 is lost
   task t_arb;
      fork
         run_master(7'h50, 1'b0, 8'h00, 1'b0);
         begin
            for (k = 0; k < 200 && sda_oe_n !== 1'b0; k = k + 1)
               @(negedge clock);
            jam_n = 1'b0;
            for (k = 0; k < 3000 && err_seen !== 1'b1; k = k + 1)
               @(negedge clock);
            jam_n = 1'b1;
         end
      join
      check_bit(m_arb_lost, 1'b1);
      check_bit(done_seen, 1'b0);
   endtask
   initial begin
      {clock, rst, fast, m_go, m_rw, s_enable, stretch, jam_n} = 8'h45;
      {m_addr, s_addr, m_tx_data, s_tx_data, rd_byte} = {7'h00, 7'h2a, 24'h000000};
      {fails, check_count} = 64'h0;
      repeat (4) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      check_bit(scl_oe_n, 1'b1);
      check_bit(sda_oe_n, 1'b1);
      check_bit(m_busy, 1'b0);
      t_write();
      t_read_fast();
      t_nack();
      t_own_write();
      t_own_read();
      t_slave_off();
      t_arb();
      tally_and_finish();
   end
   // hang guard, well beyond seven transfers
   initial begin
      #5000000;
      fails = fails + 1;
      tally_and_finish();
   end
endmodule

// ### tb/two_wire_ctrl_sva.sv
// assertion checker for the two-wire controller top
`timescale 1ns/1ps
module two_wire_ctrl_sva (
   // clock and reset
   input wire clock,
   input wire rst,
   // bus lines
   input wire scl_i,
   input wire sda_i,
   input wire scl_o,
   input wire scl_oe_n,
   input wire sda_o,
   // master side
   input wire fast,
   input wire m_go,
   input wire m_rw,
   input wire m_busy,
   input wire m_done,
   input wire m_error,
   input wire m_nack,
   input wire m_arb_lost,
   // status
   input wire bus_busy,
   input wire [3:0] mode
);
   localparam int STD_LOW = 50;
   localparam int FAST_LOW = 12;
   logic [7:0] low_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // saturating count of cycles with the clock line pulled
   always @(posedge clock or posedge rst) begin
      if (rst)
         low_cnt <= 8'h00;
      else if (scl_oe_n)
         low_cnt <= 8'h00;
      else if (low_cnt != 8'hff)
         low_cnt <= low_cnt + 8'h01;
   end
   sequence go_taken;
      m_go && !m_busy;
   endsequence
   sequence stop_seen;
      $rose(sda_i) && scl_i && $past(scl_i);
   endsequence
   AST_PULL_ONLY: assert property (!scl_o && !sda_o)
      else $error("bus line driven high");
   AST_GO_BUSY: assert property (go_taken |=> m_busy)
      else $error("accepted command did not set busy");
   AST_END_FREE: assert property ((m_done || m_error) |=> !m_busy)
      else $error("busy held after transfer end");
   AST_DONE_CLEAN: assert property (m_done |-> !m_error && !m_nack && !m_arb_lost)
      else $error("done raised with a fault");
   AST_NACK_ABORT: assert property ($rose(m_nack) |-> ##[0:300] m_error)
      else $error("nack without abort event");
   AST_ARB_ABORT: assert property ($rose(m_arb_lost) |-> ##[0:2] m_error)
      else $error("arbitration loss without abort event");
   AST_TX_MODE: assert property (go_taken ##0 !m_rw |-> ##[1:3] mode[0] && !mode[1])
      else $error("master transmit mode missing");
   AST_RX_MODE: assert property (go_taken ##0 m_rw |-> ##[1:3] mode[1] && !mode[0])
      else $error("master receive mode missing");
   AST_LOW_TIME: assert property ($rose(scl_oe_n) |-> low_cnt >= (fast ? FAST_LOW : STD_LOW))
      else $error("clock low phase too short");
   AST_STOP_FREE: assert property (stop_seen |-> ##[1:8] !bus_busy)
      else $error("bus still busy after stop");
endmodule
bind two_wire_ctrl two_wire_ctrl_sva u_sva (
   .clock(clock), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o),
   .scl_oe_n(scl_oe_n), .sda_o(sda_o), .fast(fast), .m_go(m_go), .m_rw(m_rw),
   .m_busy(m_busy), .m_done(m_done), .m_error(m_error), .m_nack(m_nack),
   .m_arb_lost(m_arb_lost), .bus_busy(bus_busy), .mode(mode));
